//--- pidcfg_regs.sv
// Summary of operation
// R1: High product identifier byte is an 8-bit register replaceable by a configuration source.
// R2: Use the loaded product byte when the loaded product or vendor field is non-zero.
// R3: If loaded product and vendor are all zero, use the OTP product value when OTP product or vendor is non-zero.
// R4: If OTP also holds zero, fall back to the hard-wired default byte.
// R5: SuperSpeed reports register unchanged; USB 2.0 low byte is XORed with bit 1.
module pidcfg_regs #(
    parameter logic [7:0] PID_LOW_DEFAULT = 8'hA5,  // Arbitrary value
    parameter logic [7:0] PID_HIGH_DEFAULT = 8'h5A  // Arbitrary value
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    // Configuration load path
    input wire pidcfg_pkg::pidcfg_wr_type I_CFG_WR,
    input wire logic I_CFG_LOAD_DONE,
    input wire pidcfg_pkg::pidcfg_otp_type I_OTP_IDENT,
    // Register read port
    input wire logic [7:0] I_CFG_RD_ADDR,
    output logic [7:0] O_CFG_RDATA,
    // Identifier in use
    output logic [15:0] O_PID_SUPERSPEED,
    output logic [15:0] O_PID_USB2,
    output pidcfg_pkg::pidcfg_src_type O_PID_SOURCE
);
    import pidcfg_pkg::*;

    logic [7:0] product_ident_low_q;
    logic [7:0] product_ident_low_d;
    logic [7:0] product_ident_high_q;
    logic [7:0] product_ident_high_d;
    logic [7:0] ld_vid_low_q;
    logic [7:0] ld_vid_high_q;
    logic [7:0] ld_pid_low_q;
    logic [7:0] ld_pid_high_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    pidcfg_src_type src_q;
    pidcfg_src_type src_d;

    // Write decode
    wire wr_vid_low = I_CFG_WR.valid && (I_CFG_WR.addr == PIDCFG_OFS_VID_LOW);
    wire wr_vid_high = I_CFG_WR.valid && (I_CFG_WR.addr == PIDCFG_OFS_VID_HIGH);
    wire wr_pid_low = I_CFG_WR.valid && (I_CFG_WR.addr == PIDCFG_OFS_PID_LOW);
    wire wr_pid_high = I_CFG_WR.valid && (I_CFG_WR.addr == PIDCFG_OFS_PID_HIGH);

    // Source qualification
    wire [PIDCFG_ID_W-1:0] ld_pid = {ld_pid_high_q, ld_pid_low_q};
    wire [PIDCFG_ID_W-1:0] ld_vid = {ld_vid_high_q, ld_vid_low_q};
    wire load_nonzero = (ld_pid != 16'h0000) || (ld_vid != 16'h0000);  // [R2]
    wire otp_nonzero = (I_OTP_IDENT.pid != 16'h0000) || (I_OTP_IDENT.vid != 16'h0000);  // [R3]

    // Resolve priority at the end of a load
    always_comb begin
        product_ident_low_d = product_ident_low_q;
        product_ident_high_d = product_ident_high_q;
        src_d = src_q;
        if (I_CFG_LOAD_DONE) begin
            if (load_nonzero) begin
                product_ident_low_d = ld_pid_low_q;  // [R2]
                product_ident_high_d = ld_pid_high_q;  // [R1] [R2]
                src_d = PIDCFG_SRC_LOAD;
            end else if (otp_nonzero) begin
                product_ident_low_d = I_OTP_IDENT.pid[7:0];  // [R3]
                product_ident_high_d = I_OTP_IDENT.pid[15:8];  // [R3]
                src_d = PIDCFG_SRC_OTP;
            end else begin
                product_ident_low_d = PID_LOW_DEFAULT;  // [R4]
                product_ident_high_d = PID_HIGH_DEFAULT;  // [R4]
                src_d = PIDCFG_SRC_DEFAULT;
            end
        end
    end

    // Read decode
    always_comb begin
        unique case (I_CFG_RD_ADDR)
            PIDCFG_OFS_PID_LOW: rdata_d = product_ident_low_q;
            PIDCFG_OFS_PID_HIGH: rdata_d = product_ident_high_q;
            default: rdata_d = PIDCFG_RDATA_RST;
        endcase
    end

    // Loaded shadow bytes
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ld_vid_low_q <= PIDCFG_SHADOW_RST;
            ld_vid_high_q <= PIDCFG_SHADOW_RST;
            ld_pid_low_q <= PIDCFG_SHADOW_RST;
            ld_pid_high_q <= PIDCFG_SHADOW_RST;
        end else begin
            if (wr_vid_low) ld_vid_low_q <= I_CFG_WR.data;
            if (wr_vid_high) ld_vid_high_q <= I_CFG_WR.data;
            if (wr_pid_low) ld_pid_low_q <= I_CFG_WR.data;
            if (wr_pid_high) ld_pid_high_q <= I_CFG_WR.data;  // [R1]
        end
    end

    // Identifier registers
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            product_ident_low_q <= PID_LOW_DEFAULT;
            product_ident_high_q <= PID_HIGH_DEFAULT;
            src_q <= PIDCFG_SRC_DEFAULT;
        end else begin
            product_ident_low_q <= product_ident_low_d;
            product_ident_high_q <= product_ident_high_d;
            src_q <= src_d;
        end
    end

    // Descriptor outputs and read data
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PID_SUPERSPEED <= {PID_HIGH_DEFAULT, PID_LOW_DEFAULT};
            O_PID_USB2 <= {PID_HIGH_DEFAULT, PID_LOW_DEFAULT ^ PIDCFG_HS_XOR_MASK};
            rdata_q <= PIDCFG_RDATA_RST;
        end else begin
            O_PID_SUPERSPEED <= {product_ident_high_d, product_ident_low_d};  // [R5]
            O_PID_USB2 <= {product_ident_high_d, product_ident_low_d ^ PIDCFG_HS_XOR_MASK};  // [R5]
            rdata_q <= rdata_d;
        end
    end

    assign O_CFG_RDATA = rdata_q;
    assign O_PID_SOURCE = src_q;

    // Checks
    sequence done_load_s;
        I_CFG_LOAD_DONE && load_nonzero;
    endsequence

    sequence done_otp_s;
        I_CFG_LOAD_DONE && !load_nonzero && otp_nonzero;
    endsequence

    sequence done_dflt_s;
        I_CFG_LOAD_DONE && !load_nonzero && !otp_nonzero;
    endsequence

    property load_pick_p;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        done_load_s |=> (O_PID_SUPERSPEED == $past(ld_pid)) && (src_q == PIDCFG_SRC_LOAD);
    endproperty

    load_pick_a: assert property (load_pick_p) else $error("loaded identifier not taken"); // [R2]

    otp_pick_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R3]
        done_otp_s |=> (O_PID_SUPERSPEED == $past(I_OTP_IDENT.pid)) && (src_q == PIDCFG_SRC_OTP))
        else $error("otp identifier not taken");

    dflt_pick_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R4]
        done_dflt_s |=> (product_ident_high_q == PID_HIGH_DEFAULT) && (product_ident_low_q == PID_LOW_DEFAULT))
        else $error("default identifier not taken");

    high_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R1]
        !I_CFG_LOAD_DONE |=> $stable(product_ident_high_q) && $stable(product_ident_low_q))
        else $error("identifier changed without a load");

    desc_ss_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R5]
        O_PID_SUPERSPEED == {product_ident_high_q, product_ident_low_q})
        else $error("superspeed descriptor differs from register");

    desc_usb2_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R5]
        (O_PID_USB2[15:8] == O_PID_SUPERSPEED[15:8]) &&
        ((O_PID_USB2[7:0] ^ O_PID_SUPERSPEED[7:0]) == PIDCFG_HS_XOR_MASK))
        else $error("usb2 descriptor low byte not altered at bit 1");

    read_high_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R1]
        (I_CFG_RD_ADDR == PIDCFG_OFS_PID_HIGH) && !I_CFG_LOAD_DONE |=> O_CFG_RDATA == product_ident_high_q)
        else $error("high byte read wrong");

    load_high_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R2]
        (I_CFG_WR.valid && I_CFG_WR.addr == PIDCFG_OFS_PID_HIGH && I_CFG_WR.data != 8'h00) ##1
        (I_CFG_LOAD_DONE && !(I_CFG_WR.valid && I_CFG_WR.addr == PIDCFG_OFS_PID_HIGH))
        |=> product_ident_high_q == $past(I_CFG_WR.data, 2))
        else $error("loaded high byte lost");

    read_low_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R2]
        (I_CFG_RD_ADDR == PIDCFG_OFS_PID_LOW) && !I_CFG_LOAD_DONE |=> O_CFG_RDATA == product_ident_low_q)
        else $error("low byte read wrong");

    read_other_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R1]
        (I_CFG_RD_ADDR != PIDCFG_OFS_PID_LOW) && (I_CFG_RD_ADDR != PIDCFG_OFS_PID_HIGH) |=> O_CFG_RDATA == PIDCFG_RDATA_RST)
        else $error("unmapped read not zero");

    shadow_pidl_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R2]
        wr_pid_low |=> ld_pid_low_q == $past(I_CFG_WR.data))
        else $error("loaded low product byte not stored");

    shadow_pidh_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R1]
        wr_pid_high |=> ld_pid_high_q == $past(I_CFG_WR.data))
        else $error("loaded high product byte not stored");

    shadow_vidl_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R2]
        wr_vid_low |=> ld_vid_low_q == $past(I_CFG_WR.data))
        else $error("loaded low vendor byte not stored");

    shadow_vidh_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R2]
        wr_vid_high |=> ld_vid_high_q == $past(I_CFG_WR.data))
        else $error("loaded high vendor byte not stored");

    shadow_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R2]
        !I_CFG_WR.valid |=> $stable(ld_pid) && $stable(ld_vid))
        else $error("loaded bytes changed without a write");

    src_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R2]
        !I_CFG_LOAD_DONE |=> $stable(src_q))
        else $error("source changed without a load");

    load_first_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R2]
        done_load_s and otp_nonzero |=> src_q == PIDCFG_SRC_LOAD)
        else $error("otp preferred over loaded identifier");

    otp_usb2_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R3]
        done_otp_s |=> O_PID_USB2 == ($past(I_OTP_IDENT.pid) ^ {8'h00, PIDCFG_HS_XOR_MASK}))
        else $error("usb2 descriptor wrong after otp pick");

    dflt_desc_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R4]
        done_dflt_s |=> (O_PID_SUPERSPEED == {PID_HIGH_DEFAULT, PID_LOW_DEFAULT}) && (src_q == PIDCFG_SRC_DEFAULT))
        else $error("default descriptor not reported");

    load_usb2_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // [R5]
        done_load_s |=> O_PID_USB2 == ($past(ld_pid) ^ {8'h00, PIDCFG_HS_XOR_MASK}))
        else $error("usb2 descriptor wrong after load pick");

endmodule // pidcfg_regs

//--- pidcfg_pkg.sv
package pidcfg_pkg;

    // Register offsets on the configuration load path
    localparam logic [7:0] PIDCFG_OFS_VID_LOW = 8'h01;
    localparam logic [7:0] PIDCFG_OFS_VID_HIGH = 8'h02;
    localparam logic [7:0] PIDCFG_OFS_PID_LOW = 8'h03;
    localparam logic [7:0] PIDCFG_OFS_PID_HIGH = 8'h04;

    // Field layout
    localparam int PIDCFG_BYTE_W = 8;
    localparam int PIDCFG_ID_W = 16;

    // High-speed descriptor alteration of the low byte
    localparam logic [7:0] PIDCFG_HS_XOR_MASK = 8'h02;

    // Shadow and read data values after reset
    localparam logic [7:0] PIDCFG_SHADOW_RST = 8'h00;
    localparam logic [7:0] PIDCFG_RDATA_RST = 8'h00;

    // Which source supplied the identifier in use
    typedef enum logic [1:0] {
        PIDCFG_SRC_DEFAULT,
        PIDCFG_SRC_OTP,
        PIDCFG_SRC_LOAD
    } pidcfg_src_type;

    // One byte write from the EEPROM load or the SMBus host
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } pidcfg_wr_type;

    // Identifier pair as held in one-time-programmable memory
    typedef struct packed {
        logic [15:0] vid;
        logic [15:0] pid;
    } pidcfg_otp_type;

endpackage

//--- pidcfg_src_model.sv
// Configuration source: four byte writes, then load finished
module pidcfg_src_model
    import pidcfg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [15:0] i_vid,
    input wire logic [15:0] i_pid,
    output pidcfg_pkg::pidcfg_wr_type o_wr,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] step = 3'h0;
    wire logic [31:0] ids = {i_pid, i_vid};
    wire logic [7:0] sel = ids[{step[1:0] - 2'h1, 3'h0} +: 8];
    wire logic live = (step != 3'h0) && (step != 3'h5);
    initial begin
        o_wr = '0;
        o_done = 1'b0;
    end
    // Idle bus keeps a stale address and toggling data
    always @(posedge i_clk) begin
        o_wr.valid <= live;
        o_wr.addr <= live ? {5'h00, step} : 8'h04;
        o_wr.data <= live ? sel : ~o_wr.data;
        o_done <= (step == 3'h5);
        step <= (step == 3'h5) ? 3'h0 : step + {2'h0, (step != 3'h0) || i_go};
    end
endmodule // pidcfg_src_model

//--- product_id_config_regs_tb.sv
module product_id_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pidcfg_pkg::*;
    localparam logic [15:0] DEF = 16'h5AA5;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    pidcfg_otp_type otp = '0;
    pidcfg_wr_type cfg_wr;
    logic load_done;
    logic [7:0] rdata;
    logic [15:0] pid_ss;
    logic [15:0] pid_u2;
    pidcfg_src_type src;
    logic go = 1'b0;
    logic [15:0] ld_vid = 16'h0000;
    logic [15:0] ld_pid = 16'h0000;
    int errors = 0;
    int n_checks = 0;
    logic [15:0] tv [6] = '{16'h0000, 16'h5678, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] tp [6] = '{16'h1234, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
    logic [31:0] to [6] = '{32'hDEADBEEF, 32'h00010002, 32'h00009ABC, 32'h11110000, 32'h0, 32'h0};
    logic [15:0] te [6] = '{16'h1234, 16'h0000, 16'h9ABC, 16'h0000, DEF, 16'h0001};
    pidcfg_src_type ts [6] = '{PIDCFG_SRC_LOAD, PIDCFG_SRC_LOAD, PIDCFG_SRC_OTP, PIDCFG_SRC_OTP,
        PIDCFG_SRC_DEFAULT, PIDCFG_SRC_LOAD};
    always #25 clk_sys = ~clk_sys;
    pidcfg_regs #(.PID_LOW_DEFAULT(DEF[7:0]), .PID_HIGH_DEFAULT(DEF[15:8])) u_pidcfg_regs (
        .I_CLK_SYS(clk_sys), .I_RESET_N(reset_n), .I_CFG_WR(cfg_wr), .I_CFG_LOAD_DONE(load_done),
        .I_OTP_IDENT(otp), .I_CFG_RD_ADDR(rd_addr), .O_CFG_RDATA(rdata),
        .O_PID_SUPERSPEED(pid_ss), .O_PID_USB2(pid_u2), .O_PID_SOURCE(src));
    pidcfg_src_model u_pidcfg_src_model (.i_clk(clk_sys), .i_go(go), .i_vid(ld_vid), .i_pid(ld_pid),
        .o_wr(cfg_wr), .o_done(load_done));
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd_addr <= a;
        @(posedge clk_sys);
        #1 check("read data", {8'h00, rdata}, {8'h00, exp});
    endtask
    task ids(input logic [15:0] exp, input pidcfg_src_type s);
        check("superspeed id", pid_ss, exp);
        check("usb2 id", pid_u2, exp ^ {8'h00, PIDCFG_HS_XOR_MASK});
        check("source", {14'h0000, src}, {14'h0000, s});
    endtask
    task load(input logic [15:0] v, input logic [15:0] p, input logic [31:0] o);
        int n;
        n = 0;
        @(posedge clk_sys);
        ld_vid <= v;
        ld_pid <= p;
        otp <= o;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (load_done !== 1'b1 && n < 10);
        check("load done", {15'h0000, load_done}, 16'h0001);
        #1;
    endtask
    task report_and_stop;
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        #1 ids(DEF, PIDCFG_SRC_DEFAULT);
        rd(PIDCFG_OFS_PID_LOW, DEF[7:0]);
        rd(PIDCFG_OFS_PID_HIGH, DEF[15:8]);
        rd(8'h05, 8'h00);
        $display("Test reset defaults done");
        for (int i = 0; i < 6; i++) begin
            load(tv[i], tp[i], to[i]);
            ids(te[i], ts[i]);
            rd(PIDCFG_OFS_PID_HIGH, te[i][15:8]);
            $display("Test load %0d done", i);
        end
        report_and_stop;
    end
endmodule // product_id_config_regs_tb
